// File: core/dac_link_host.sv
// Added by the designer: register access over AHB-Lite and the address map.
`timescale 1ns/1ps
`include "dac_link_consts.svh"

module dac_link_host #(
  parameter int DIV_W = 8,
  parameter int SETTLE_CYC = `SETTLE_CYC
) (
  // Clock, reset and enable
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic ce,
  // AHB-Lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic [31:0] hrdata,
  output logic hresp,
  // Serial link towards the converter
  dac_link_if.host link
);
  import dac_link_pkg::*;

  localparam int ST_W = 16;

  initial begin
    // Divider must fit below the split bit of the control word
    if (DIV_W < 5 || DIV_W > 8 || SETTLE_CYC < 1
        || SETTLE_CYC >= 65536) begin
      $error("dac_link_host parameters out of range");
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Bus slave, zero wait states

  logic wr_q;
  logic [31:0] addr_q;
  logic [31:0] rdata_q;

  wire logic addr_ph = hsel & hready & (htrans == `HTRANS_NONSEQ)
                     & (hsize == `HSIZE_WORD);
  wire logic sel_word = addr_q == `REG_WORD;
  wire logic sel_ctrl = addr_q == `REG_CTRL;
  wire logic wr_word = wr_q & sel_word;
  wire logic wr_ctrl = wr_q & sel_ctrl;

  host_state_t st_q;
  word_t word_q;
  logic [DIV_W-1:0] div_q;
  logic split_q;
  logic [ST_W-1:0] settle_q;

  wire logic busy = st_q != H_IDLE;
  wire logic settled = settle_q == '0;
  wire logic start = wr_word & ~busy;

  // Half periods below the link minimum are raised to it
  wire logic [DIV_W-1:0] div_min = DIV_W'(`THALF_CYC);
  wire logic [DIV_W-1:0] div_in = hwdata[DIV_W-1:0] < div_min ? div_min
                                : hwdata[DIV_W-1:0];
  wire logic [31:0] rd_status = {30'h0000_0000, settled, busy};
  wire logic [31:0] rd_ctrl = {23'h00_0000, split_q, 8'(div_q)};
  wire logic [31:0] rd_mux = (haddr == `REG_WORD) ? {16'h0000, word_q}
                           : (haddr == `REG_STATUS) ? rd_status
                           : (haddr == `REG_CTRL) ? rd_ctrl
                           : 32'h0000_0000;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_q <= 1'b0;
      addr_q <= '0;
      rdata_q <= '0;
    end else if (ce) begin
      wr_q <= addr_ph & hwrite;
      addr_q <= haddr;
      if (addr_ph && !hwrite) begin
        rdata_q <= rd_mux;
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      div_q <= DIV_W'(`DIV_RESET);
      split_q <= 1'b0;
    end else if (ce && wr_ctrl) begin
      div_q <= div_in;
      split_q <= hwdata[`CTRL_SPLIT];
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Link sequencer

  logic [ST_W-1:0] tmr_q;
  logic [4:0] bit_q;
  word_t tx_q;
  logic sclk_q;
  logic cs_n_q;
  logic din_q;

  wire logic tmr_done = tmr_q == '0;
  wire logic last_bit = bit_q == 5'(`WORD_BITS - 1);
  wire logic half_bit = bit_q == 5'(`HALF_BITS - 1);
  wire logic [ST_W-1:0] half = ST_W'(div_q);
  // Sub-bits are forced to zero whatever software wrote
  wire word_t tx_in = {hwdata[`WORD_BITS-1:`SUB_BITS],
                       {`SUB_BITS{1'b0}}};

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      st_q <= H_IDLE;
      tmr_q <= '0;
      bit_q <= '0;
      tx_q <= '0;
      word_q <= '0;
      sclk_q <= 1'b0;
      cs_n_q <= 1'b1;
      din_q <= 1'b0;
    end else if (ce) begin
      if (!tmr_done) begin
        tmr_q <= tmr_q - 1'b1;
      end
      case (st_q)
        H_IDLE: begin
          if (start) begin
            tx_q <= tx_in;
            word_q <= tx_in;
            din_q <= tx_in[`WORD_BITS-1];
            cs_n_q <= 1'b0;
            bit_q <= '0;
            tmr_q <= ST_W'(`TCSS_CYC);
            st_q <= H_SETUP;
          end
        end
        H_SETUP, H_LOW: begin
          if (tmr_done) begin
            sclk_q <= 1'b1;
            tmr_q <= half;
            st_q <= H_HIGH;
          end
        end
        H_HIGH: begin
          if (tmr_done) begin
            sclk_q <= 1'b0;
            bit_q <= bit_q + 1'b1;
            tx_q <= {tx_q[`WORD_BITS-2:0], 1'b0};
            din_q <= tx_q[`WORD_BITS-2];
            tmr_q <= half;
            if (last_bit) begin
              cs_n_q <= 1'b1;
              din_q <= 1'b0;
              tmr_q <= ST_W'(`TCSW_CYC);
              st_q <= H_REST;
            end else if (split_q && half_bit) begin
              st_q <= H_GAP;
            end else begin
              st_q <= H_LOW;
            end
          end
        end
        // Clock parked low between the two bytes, select stays low
        H_GAP: begin
          if (tmr_done) begin
            tmr_q <= half;
            st_q <= H_LOW;
          end
        end
        H_REST: begin
          if (tmr_done) begin
            st_q <= H_IDLE;
          end
        end
        default: begin
          st_q <= H_IDLE;
        end
      endcase
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Output settle timer, restarted by a word that wakes the converter

  wire logic [1:0] sent_op = word_q[`CMD_LO+1:`CMD_LO];
  wire logic wake = (st_q == H_HIGH) & tmr_done & last_bit
                  & (sent_op == `CMD_LOAD_UPDATE || sent_op == `CMD_RESTORE);

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      settle_q <= ST_W'(SETTLE_CYC);
    end else if (ce) begin
      if (wake) begin
        settle_q <= ST_W'(SETTLE_CYC);
      end else if (!settled) begin
        settle_q <= settle_q - 1'b1;
      end
    end
  end

  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign hrdata = rdata_q;
  assign link.sclk = sclk_q;
  assign link.cs_n = cs_n_q;
  assign link.din = din_q;

endmodule : dac_link_host

// File: core/dac_word_device.sv
`timescale 1ns/1ps
`include "dac_link_consts.svh"

module dac_word_device (
  // Clock, reset and enable
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic ce,
  // Serial link from the controller
  dac_link_if.device link,
  // Code towards the conversion stage
  output dac_link_pkg::code_t code_value,
  output dac_link_pkg::code_t input_code,
  output logic shutdown,
  // Word events and last decoded command
  output logic word_done,
  output logic word_dropped,
  output dac_link_pkg::cmd_t last_cmd
);
  import dac_link_pkg::*;

  localparam int CNT_W = 5;
  localparam logic [CNT_W-1:0] CNT_FULL = CNT_W'(`WORD_BITS);
  localparam logic [CNT_W-1:0] CNT_MAX = '1;

  //////////////////////////////////////////////////////////////////////////
  // Pin synchronisers

  // The link clock is slow against hclk, so it is sampled, not used
  logic [2:0] pin_level;
  logic [2:0] pin_rise;
  logic [2:0] pin_prev;

  // Start at the idle levels, so leaving reset shows no false select edge
  edge_sync #(
    .W(3),
    .RST_VAL(`LINK_IDLE)
  ) u_pins (
    .hclk(hclk),
    .hresetn(hresetn),
    .ce(ce),
    .async_in({link.cs_n, link.sclk, link.din}),
    .level(pin_level),
    .rise(pin_rise),
    .prev(pin_prev)
  );

  wire logic din_s = pin_level[0];
  wire logic sclk_rise = pin_rise[1];
  wire logic cs_high = pin_level[2];
  wire logic cs_rise = pin_rise[2];
  // Low in the previous sample: the frame is open
  wire logic cs_open = ~pin_prev[2];

  //////////////////////////////////////////////////////////////////////////
  // Shift register and bit counter

  word_t shift_q;
  logic [CNT_W-1:0] cnt_q;

  // A clock edge counts only inside a frame
  wire logic shift_en = sclk_rise & cs_open;

  // The last edge may land in the same sample as the closing edge
  wire word_t word_w = shift_en ? {shift_q[`WORD_BITS-2:0], din_s}
                                : shift_q;
  wire logic cnt_sat = cnt_q == CNT_MAX;
  wire logic [CNT_W-1:0] cnt_inc = cnt_sat ? cnt_q : cnt_q + 1'b1;
  wire logic [CNT_W-1:0] cnt_w = shift_en ? cnt_inc : cnt_q;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      shift_q <= '0;
    end else if (ce && shift_en) begin
      shift_q <= word_w;
    end
  end

  // Idle link keeps the counter at zero, so stray edges never count
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cnt_q <= '0;
    end else if (ce) begin
      if (cs_high) begin
        cnt_q <= '0;
      end else begin
        cnt_q <= cnt_w;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Word decode

  // Anything but exactly sixteen bits is thrown away
  wire logic word_ok = cnt_w == CNT_FULL;
  wire logic take = cs_rise & word_ok;
  wire logic drop = cs_rise & ~word_ok;

  wire cmd_t cmd_w = word_w[`CMD_HI:`CMD_LO];
  wire logic [1:0] op_w = cmd_w[1:0];
  // Sub-bits in word_w[2:0] are never read
  wire code_t code_w = word_w[`CODE_HI:`CODE_LO];

  wire logic op_load_upd = take & (op_w == `CMD_LOAD_UPDATE);
  wire logic op_load_in = take & (op_w == `CMD_LOAD_INPUT);
  wire logic op_restore = take & (op_w == `CMD_RESTORE);
  wire logic op_upper = take & (op_w == `CMD_SHUT_OR_NOP);
  // Top command bit splits shutdown from no-operation
  wire logic op_shut = op_upper & cmd_w[2];

  //////////////////////////////////////////////////////////////////////////
  // Double-buffered code registers

  code_t input_q;
  code_t conv_q;
  logic shut_q;

  // Input register is untouched by shutdown, so restore recalls it
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      input_q <= `CODE_RESET;
    end else if (ce) begin
      if (op_load_upd || op_load_in) begin
        input_q <= code_w;
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      conv_q <= `CODE_RESET;
    end else if (ce) begin
      if (op_load_upd) begin
        conv_q <= code_w;
      end else if (op_restore) begin
        conv_q <= input_q;
      end
    end
  end

  // Decode carries on in shutdown; only these commands wake it
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      shut_q <= 1'b0;
    end else if (ce) begin
      if (op_shut) begin
        shut_q <= 1'b1;
      end else if (op_load_upd || op_restore) begin
        shut_q <= 1'b0;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Event outputs

  logic done_q;
  logic drop_q;
  cmd_t last_cmd_q;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      done_q <= 1'b0;
      drop_q <= 1'b0;
    end else if (ce) begin
      done_q <= take;
      drop_q <= drop;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      last_cmd_q <= '0;
    end else if (ce && take) begin
      last_cmd_q <= cmd_w;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Outputs, all straight from flip-flops

  assign code_value = conv_q;
  assign input_code = input_q;
  assign shutdown = shut_q;
  assign word_done = done_q;
  assign word_dropped = drop_q;
  assign last_cmd = last_cmd_q;

endmodule : dac_word_device

// File: core/edge_sync.sv
`timescale 1ns/1ps

module edge_sync #(
  parameter int W = 3,
  parameter logic [W-1:0] RST_VAL = '0
) (
  // Clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic ce,
  // Asynchronous inputs and their synchronised views
  input wire logic [W-1:0] async_in,
  output logic [W-1:0] level,
  output logic [W-1:0] rise,
  output logic [W-1:0] prev
);

  initial begin
    if (W < 1) begin
      $error("edge_sync needs at least one bit");
    end
  end

  logic [W-1:0] meta_q;
  logic [W-1:0] sync_q;
  logic [W-1:0] last_q;

  // First stage feeds only the second stage
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      meta_q <= RST_VAL;
      sync_q <= RST_VAL;
      last_q <= RST_VAL;
    end else if (ce) begin
      meta_q <= async_in;
      sync_q <= meta_q;
      last_q <= sync_q;
    end
  end

  assign level = sync_q;
  assign prev = last_q;
  assign rise = sync_q & ~last_q;

endmodule : edge_sync

// File: inc/dac_link_consts.svh
`ifndef DAC_LINK_CONSTS_SVH
`define DAC_LINK_CONSTS_SVH

// Serial word layout, most significant bit sent first
`define WORD_BITS 16
`define HALF_BITS 8
`define CODE_BITS 10
`define CMD_HI 15
`define CMD_LO 13
`define CMD_TOP 15
`define CODE_HI 12
`define CODE_LO 3
`define SUB_BITS 3

// Command encodings of the lower two command bits
`define CMD_LOAD_UPDATE 2'h0
`define CMD_LOAD_INPUT 2'h1
`define CMD_RESTORE 2'h2
`define CMD_SHUT_OR_NOP 2'h3

// Idle levels of select, clock and data, in synchroniser bit order
`define LINK_IDLE 3'h4

// Reset value of both code registers
`define CODE_RESET 10'h000

// Timing, clock rate in MHz and times as printed
`define CLK_MHZ 200
`define TCSS_NS 40
`define TCSW_NS 100
`define THALF_NS 40
`define SETTLE_US 20
`define TCSS_CYC ((`TCSS_NS * `CLK_MHZ + 999) / 1000)
`define TCSW_CYC ((`TCSW_NS * `CLK_MHZ + 999) / 1000)
`define THALF_CYC ((`THALF_NS * `CLK_MHZ + 999) / 1000)
`define SETTLE_CYC (`SETTLE_US * `CLK_MHZ)

// Controller register map, byte addresses
`define REG_WORD 32'h0000_0000
`define REG_STATUS 32'h0000_0004
`define REG_CTRL 32'h0000_0008
`define STAT_BUSY 0
`define STAT_SETTLED 1
`define CTRL_SPLIT 8
`define DIV_RESET 8'h0a
`define HTRANS_NONSEQ 2'h2
`define HSIZE_WORD 3'h2

`endif

// File: inc/dac_link_if.sv
`timescale 1ns/1ps

interface dac_link_if;
  logic cs_n;
  logic sclk;
  logic din;

  modport host (
    output cs_n,
    output sclk,
    output din
  );

  modport device (
    input cs_n,
    input sclk,
    input din
  );
endinterface : dac_link_if

// File: inc/dac_link_pkg.sv
package dac_link_pkg;

  typedef logic [9:0] code_t;
  typedef logic [15:0] word_t;
  typedef logic [2:0] cmd_t;

  typedef enum logic [5:0] {
    H_IDLE  = 6'h01,
    H_SETUP = 6'h02,
    H_LOW   = 6'h04,
    H_HIGH  = 6'h08,
    H_GAP   = 6'h10,
    H_REST  = 6'h20
  } host_state_t;

endpackage : dac_link_pkg

// File: tb/dac_link_assertions.sv
`timescale 1ns/1ps

module dac_link_assertions (
  // Clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // Link wires
  input wire logic cs_n,
  input wire logic sclk,
  input wire logic din,
  // Device outputs
  input wire dac_link_pkg::code_t code_value,
  input wire dac_link_pkg::code_t input_code,
  input wire logic shutdown,
  input wire logic word_done,
  input wire logic word_dropped,
  input wire dac_link_pkg::cmd_t last_cmd
);
  import dac_link_pkg::*;

  default clocking cb @(posedge hclk);
  endclocking
  default disable iff (!hresetn);

  ////////////////////////////////////////////////////////////
  // Registers and the word pulse move at the same edge; two
  // samples back is safely before the word was acted on.
  a_conv_on_word: assert property (!$stable(code_value) |-> word_done)
    else $error("converter code moved without a word");
  a_input_on_word: assert property (!$stable(input_code) |-> word_done)
    else $error("input code moved without a word");
  a_shut_enter: assert property ($rose(shutdown) |->
    word_done && last_cmd == 3'h7)
    else $error("shutdown entered by a wrong command");
  a_shut_leave: assert property ($fell(shutdown) |->
    word_done && !last_cmd[0])
    else $error("shutdown left by a wrong command");
  a_shut_keeps: assert property (word_done && last_cmd == 3'h7 |->
    shutdown && input_code == $past(input_code, 2))
    else $error("shutdown word lost the input code");
  a_load_both: assert property (word_done && last_cmd[1:0] == 2'h0 |->
    code_value == input_code && !shutdown)
    else $error("load and update word mismatch");
  a_load_input: assert property (word_done && last_cmd[1:0] == 2'h1 |->
    code_value == $past(code_value, 2) && shutdown == $past(shutdown, 2))
    else $error("input-only load touched converter or shutdown");
  a_copy_input: assert property (word_done && last_cmd[1:0] == 2'h2 |->
    code_value == input_code && input_code == $past(input_code, 2)
    && !shutdown)
    else $error("restore word did not copy the input code");
  a_nop_still: assert property (word_done && last_cmd == 3'h3 |->
    code_value == $past(code_value, 2) && input_code == $past(input_code, 2))
    else $error("no-op word changed a register");
  a_pulse_late: assert property (word_done |-> cs_n && !$past(cs_n, 6))
    else $error("word acted on away from chip select rise");
  a_pulse_single: assert property (word_done |=> !word_done && !word_dropped)
    else $error("word pulse longer than one cycle");
  a_clock_idle: assert property (cs_n |-> !sclk)
    else $error("serial clock high outside a frame");

  c_shutdown: cover property (word_done && last_cmd == 3'h7);
  c_wake: cover property ($fell(shutdown));
  c_restore: cover property (word_done && last_cmd[1:0] == 2'h2);
endmodule : dac_link_assertions

// File: tb/serial_dac_word_loader_tb_top.sv
`timescale 1ns/1ps
`include "dac_link_consts.svh"

module serial_dac_word_loader_tb_top;
  import dac_link_pkg::*;

  logic hclk, hresetn, hsel, hwrite, hreadyout, hresp;
  logic [31:0] haddr, hwdata, hrdata;
  logic [1:0] htrans;
  logic [2:0] hsize;
  code_t cv_a, ic_a, cv_b, ic_b;
  cmd_t lc_a;
  logic sd_a, sd_b, wd_a, wp_a, wd_b, wp_b;
  logic [15:0] mon_q;
  int mon_n, n_done, n_drop;
  int error_cnt = 0;
  int checks = 0;

  dac_link_if link_a ();
  dac_link_if link_b ();

  dac_link_host #(.SETTLE_CYC(20)) dac_link_host_i (
    .hclk(hclk), .hresetn(hresetn), .ce(1'b1), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hreadyout), .hreadyout(hreadyout), .hrdata(hrdata),
    .hresp(hresp), .link(link_a));
  dac_word_device dac_word_device_i (
    .hclk(hclk), .hresetn(hresetn), .ce(1'b1), .link(link_a),
    .code_value(cv_a), .input_code(ic_a), .shutdown(sd_a),
    .word_done(wd_a), .word_dropped(wp_a), .last_cmd(lc_a));
  // Second device on a bench-driven link for faults of the far side
  dac_word_device dac_word_device_b_i (
    .hclk(hclk), .hresetn(hresetn), .ce(1'b1), .link(link_b),
    .code_value(cv_b), .input_code(ic_b), .shutdown(sd_b),
    .word_done(wd_b), .word_dropped(wp_b), .last_cmd());
  dac_link_assertions dac_link_assertions_i (
    .hclk(hclk), .hresetn(hresetn), .cs_n(link_a.cs_n),
    .sclk(link_a.sclk), .din(link_a.din), .code_value(cv_a),
    .input_code(ic_a), .shutdown(sd_a), .word_done(wd_a),
    .word_dropped(wp_a), .last_cmd(lc_a));

  ////////////////////////////////////////////////////////////
  always @(posedge link_a.sclk) if (!link_a.cs_n) begin
    mon_q = {mon_q[14:0], link_a.din};
    mon_n++;
  end
  always @(posedge hclk) begin
    n_done <= n_done + 32'(wd_b);
    n_drop <= n_drop + 32'(wp_b);
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic print_verdict();
    $display("checks %0d error_cnt %0d", checks, error_cnt);
    if (error_cnt == 0 && checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask : print_verdict

  task automatic ahb(input logic wr, input logic [31:0] a,
                     input logic [31:0] d, output logic [31:0] r);
    hsel <= 1'b1;
    haddr <= a;
    hwrite <= wr;
    htrans <= `HTRANS_NONSEQ;
    hsize <= `HSIZE_WORD;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    htrans <= 2'h0;
    hsel <= 1'b0;
    hwdata <= d;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    r = hrdata;
  endtask : ahb

  task automatic host_word(input logic [15:0] w);
    logic [31:0] r;
    int n;
    mon_n = 0;
    n = 0;
    ahb(1'b1, `REG_WORD, {16'h0000, w}, r);
    while (wd_a !== 1'b1 && n < 2000) begin
      @(posedge hclk);
      n++;
    end
    check(32'(wd_a), 32'h0000_0001);
    do ahb(1'b0, `REG_STATUS, 32'h0000_0000, r); while (r[`STAT_BUSY] !== 1'b0);
    check(32'(mon_n), 32'h0000_0010);
    check(mon_q, {w[15:3], 3'h0});
  endtask : host_word

  // Bench frame: 80 ns clock, runs only inside the frame
  task automatic b_frame(input logic [15:0] w, input int n, input logic split);
    link_b.cs_n <= 1'b0;
    repeat (8) @(posedge hclk);
    for (int i = 0; i < n; i++) begin
      link_b.din <= w[15 - (i % 16)];
      link_b.sclk <= 1'b0;
      repeat (split && i == 8 ? 24 : 8) @(posedge hclk);
      link_b.sclk <= 1'b1;
      repeat (8) @(posedge hclk);
    end
    link_b.sclk <= 1'b0;
    link_b.din <= ~link_b.din;
    repeat (8) @(posedge hclk);
    link_b.cs_n <= 1'b1;
    repeat (40) @(posedge hclk);
  endtask : b_frame

  ////////////////////////////////////////////////////////////
  task automatic t_cmds();
    logic [15:0] w [10] = '{16'h2aa8, 16'h9ffd, 16'ha008, 16'hf234,
      16'h6abc, 16'h3550, 16'h4fff, 16'he000, 16'h1000, 16'hc555};
    code_t ei [10] = '{10'h155, 10'h3ff, 10'h001, 10'h001, 10'h001,
      10'h2aa, 10'h2aa, 10'h2aa, 10'h200, 10'h200};
    code_t ec [10] = '{10'h000, 10'h3ff, 10'h3ff, 10'h3ff, 10'h3ff,
      10'h3ff, 10'h2aa, 10'h2aa, 10'h200, 10'h200};
    logic es [10] = '{0, 0, 0, 1, 1, 1, 0, 1, 0, 0};
    for (int i = 0; i < 10; i++) begin
      host_word(w[i]);
      check(ic_a, ei[i]);
      check(cv_a, ec[i]);
      check(sd_a, es[i]);
      check(lc_a, w[i][15:13]);
    end
  endtask : t_cmds

  task automatic t_split();
    logic [31:0] r;
    ahb(1'b0, `REG_CTRL, 32'h0000_0000, r);
    check(r, {24'h00_0000, `DIV_RESET});
    ahb(1'b1, `REG_CTRL, 32'h0000_0108, r);
    ahb(1'b0, `REG_CTRL, 32'h0000_0000, r);
    check(r, 32'h0000_0108);
    ahb(1'b0, 32'h0000_000c, 32'h0000_0000, r);
    check(r, 32'h0000_0000);
    host_word(16'h0ff8);
    check(cv_a, 10'h1ff);
  endtask : t_split

  task automatic t_link_b();
    int d0;
    int p0;
    d0 = n_done;
    p0 = n_drop;
    // No frame has run on this link yet, so no drop may have been seen
    check(32'(p0), 32'h0000_0000);
    b_frame(16'h2aa8, 16, 1'b1);
    check(ic_b, 10'h155);
    b_frame(16'h1000, 15, 1'b0);
    check(cv_b, 10'h000);
    b_frame(16'h1000, 17, 1'b0);
    check(ic_b, 10'h155);
    // Clock and data wiggle with chip select high: no word may form
    for (int i = 0; i < 40; i++) begin
      link_b.sclk <= i[0];
      link_b.din <= ~i[1];
      repeat (8) @(posedge hclk);
    end
    repeat (40) @(posedge hclk);
    check(32'(n_drop - p0), 32'h0000_0002);
    check(32'(n_done - d0), 32'h0000_0001);
    b_frame(16'h0ff8, 16, 1'b0);
    check(cv_b, 10'h1ff);
    check(sd_b, 1'b0);
  endtask : t_link_b

  initial begin
    hclk = 1'b0;
    forever #2.5 hclk = ~hclk;
  end

  initial begin
    #200_000;
    error_cnt++;
    print_verdict();
  end

  initial begin
    logic [31:0] r;
    hresetn = 1'b0;
    hsel = 1'b0;
    haddr = 32'h0000_0000;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize = 3'h0;
    hwdata = 32'h0000_0000;
    n_done = 0;
    n_drop = 0;
    link_b.cs_n = 1'b1;
    link_b.sclk = 1'b0;
    link_b.din = 1'b0;
    repeat (12) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    check({cv_a, ic_a, sd_a}, 21'h00_0000);
    check({cv_b, ic_b, sd_b}, 21'h00_0000);
    // Settle timer starts full after reset and runs out in 20 cycles
    ahb(1'b0, `REG_STATUS, 32'h0000_0000, r);
    check(r, 32'h0000_0000);
    repeat (20) @(posedge hclk);
    ahb(1'b0, `REG_STATUS, 32'h0000_0000, r);
    check(r, 32'h0000_0002);
    t_cmds();
    t_split();
    t_link_b();
    print_verdict();
  end
endmodule : serial_dac_word_loader_tb_top
